/* File: hdl/phone_tdm_pkg.sv */
package phone_tdm_pkg;
  localparam logic [7:0] ADDR_CODEC_GAIN_1   = 8'h0A;
  localparam logic [7:0] ADDR_CODEC_GAIN_2   = 8'h0B;
  localparam logic [7:0] ADDR_TRANSDUCER     = 8'h0E;
  localparam logic [7:0] ADDR_GENERAL        = 8'h0F;
  localparam logic [7:0] ADDR_WATCHDOG_KEY   = 8'h11;
  localparam logic [7:0] ADDR_SEGMENT_1      = 8'h12;
  localparam logic [7:0] ADDR_SEGMENT_2      = 8'h13;
  localparam logic [7:0] ADDR_CONTROL_SLOT   = 8'h14;
  localparam logic [7:0] ADDR_SLOT_TIMING    = 8'h15;
  localparam logic [7:0] ADDR_LOOPBACK       = 8'h16;
  localparam logic [7:0] ADDR_RECEIVE_GAIN   = 8'h1D;
  localparam logic [7:0] ADDR_SIGNAL_PROC    = 8'h1E;
  localparam logic [7:0] ADDR_TX_AUDIO_GAIN  = 8'h20;
  localparam logic [7:0] ADDR_TX_KEYTONE     = 8'h21;
  localparam logic [7:0] ADDR_TONE_COEF_1    = 8'h23;
  localparam logic [7:0] ADDR_TONE_COEF_2    = 8'h24;
  localparam logic [7:0] ADDR_WARBLE_RATE    = 8'h26;
  // storage index of each register that the logic itself reads
  localparam int NUM_REGS = 16;
  localparam logic [3:0] IDX_CODEC_GAIN_2  = 4'h1;
  localparam logic [3:0] IDX_GENERAL       = 4'h3;
  localparam logic [3:0] IDX_CONTROL_SLOT  = 4'h6;
  localparam logic [3:0] IDX_SLOT_TIMING   = 4'h7;
  localparam logic [3:0] IDX_LOOPBACK      = 4'h8;
  localparam logic [3:0] IDX_SIGNAL_PROC   = 4'hA;
  localparam logic [3:0] IDX_TONE_COEF_1   = 4'hD;
  localparam logic [3:0] IDX_TONE_COEF_2   = 4'hE;
  localparam logic [3:0] IDX_WARBLE_RATE   = 4'hF;
  localparam logic [7:0] RESET_REG          = 8'h00;
  localparam logic [7:0] RESET_CONTROL_SLOT = 8'hFF;
  // field positions
  localparam int BIT_C_CHANNEL_EN   = 0;
  localparam int BIT_B1_EN          = 1;
  localparam int BIT_B2_EN          = 2;
  localparam int BIT_INBOUND_LOOP   = 0;
  localparam int BIT_OUTBOUND_LOOP  = 1;
  localparam int BIT_ROUTE_EN       = 0;
  localparam int BIT_TONE_OPTION    = 0;
  localparam int POS_ATTEN          = 4;
  localparam int KEY_BITS           = 5;
  localparam logic [4:0] WATCHDOG_KEY = 5'h0A;
  // frame structure
  localparam int SLOTS_PER_FRAME    = 32;
  localparam int BITS_PER_SLOT      = 8;
  localparam int WDOG_FRAMES        = 4096;
endpackage

/* File: hdl/phone_tdm_slot_watchdog_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
module phone_tdm_slot_watchdog_ctrl #(
  parameter int WDOG_FRAMES = phone_tdm_pkg::WDOG_FRAMES
) (
  input  wire logic       clk_sys_i,
  input  wire logic       reset_i,
  input  wire logic       power_up_reset_n_i,
  input  wire logic       bit_clock_in_i,
  input  wire logic       frame_pulse_in_i,
  input  wire logic       tdm_data_in_i,
  output logic            tdm_data_out_o,
  output logic            tdm_data_out_oe_o,
  input  wire logic [7:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  input  wire logic       reg_wr_i,
  input  wire logic       reg_rd_i,
  output logic      [7:0] reg_rdata_o,
  output logic            reg_rvalid_o,
  input  wire logic [7:0] pcm_tx_byte_i,
  output logic      [7:0] pcm_rx_byte_o,
  output logic            pcm_rx_valid_o,
  output logic            codec_tone_mute_o,
  output logic            tone_gate_o,
  output logic            loudness_enable_o,
  output logic      [1:0] ringer_tone_attenuation_o,
  output logic            watchdog_out_o
);
  localparam int CW = $clog2(WDOG_FRAMES) + 1;
  localparam logic [CW-1:0] WDOG_LAST = CW'(WDOG_FRAMES - 1);

  typedef struct packed {
    logic                                         c4_s1, c4_s2, c4_s3;
    logic                                         fp_s1, fp_s2, fp_s3;
    logic                                         din_s1, din_s2;
    logic                                         por_s1, por_s2, por_s3;
    logic                                         framed;
    logic                                         ph;
    logic [7:0]                                   bitcnt;
    logic [7:0]                                   tx_sh;
    logic [7:0]                                   rx_sh;
    logic                                         last_in;
    logic [7:0]                                   cch_rx;
    logic                                         dout;
    logic                                         doe;
    logic [7:0]                                   pcm_rx;
    logic                                         pcm_v;
    logic [phone_tdm_pkg::NUM_REGS-1:0][7:0]      regs;
    logic [7:0]                                   rdata;
    logic                                         rvalid;
    logic [CW-1:0]                                wcnt;
    logic                                         wout;
    logic [7:0]                                   half_cnt;
    logic [7:0]                                   warb_cnt;
    logic                                         tsel;
    logic                                         sq;
    logic                                         gate;
    logic                                         loud;
    logic [1:0]                                   atten;
    logic                                         mute;
  } state_s;

  state_s s_q;
  state_s s_d;
  state_s rst_v;

  // decodes an address into {present, storage index}
  function automatic logic [4:0] reg_slot(input logic [7:0] a);
    logic [4:0] r;
    r = 5'h00;
    unique case (a)
      phone_tdm_pkg::ADDR_CODEC_GAIN_1:  r = 5'h10;
      phone_tdm_pkg::ADDR_CODEC_GAIN_2:  r = 5'h11;
      phone_tdm_pkg::ADDR_TRANSDUCER:    r = 5'h12;
      phone_tdm_pkg::ADDR_GENERAL:       r = 5'h13;
      phone_tdm_pkg::ADDR_SEGMENT_1:     r = 5'h14;
      phone_tdm_pkg::ADDR_SEGMENT_2:     r = 5'h15;
      phone_tdm_pkg::ADDR_CONTROL_SLOT:  r = 5'h16;
      phone_tdm_pkg::ADDR_SLOT_TIMING:   r = 5'h17;
      phone_tdm_pkg::ADDR_LOOPBACK:      r = 5'h18;
      phone_tdm_pkg::ADDR_RECEIVE_GAIN:  r = 5'h19;
      phone_tdm_pkg::ADDR_SIGNAL_PROC:   r = 5'h1A;
      phone_tdm_pkg::ADDR_TX_AUDIO_GAIN: r = 5'h1B;
      phone_tdm_pkg::ADDR_TX_KEYTONE:    r = 5'h1C;
      phone_tdm_pkg::ADDR_TONE_COEF_1:   r = 5'h1D;
      phone_tdm_pkg::ADDR_TONE_COEF_2:   r = 5'h1E;
      phone_tdm_pkg::ADDR_WARBLE_RATE:   r = 5'h1F;
      default:                           r = 5'h00;
    endcase
    return r;
  endfunction

  function automatic state_s reset_state();
    state_s r;
    r = '0;
    for (int i = 0; i < phone_tdm_pkg::NUM_REGS; i++) begin
      r.regs[i] = phone_tdm_pkg::RESET_REG;
    end
    r.regs[phone_tdm_pkg::IDX_CONTROL_SLOT] = phone_tdm_pkg::RESET_CONTROL_SLOT;
    // reset pin idles high; a cleared synchroniser would fake a power-up reset
    {r.por_s1, r.por_s2, r.por_s3} = 3'b111;
    return r;
  endfunction

  logic       c4_fall;
  logic       fp_low;
  logic       fp_fall;
  logic       drive_ev;
  logic       sample_ev;
  logic [7:0] drive_bit;
  logic       c_en;
  logic       b1_en;
  logic       b2_en;
  logic       lb_in;
  logic       lb_out;
  logic       route_en;
  logic       tone_mode;
  logic       key_wr;
  logic       key_ok;
  logic [4:0] wslot;
  logic [4:0] rslot;
  logic       rin;
  logic [7:0] rx_byte;
  logic [7:0] load_byte;
  logic [7:0] coef;

  always_comb begin
    s_d = s_q;
    rst_v = reset_state();
    rx_byte = '0;
    load_byte = '0;
    // first stage of each synchroniser feeds only the second
    s_d.c4_s1  = bit_clock_in_i;
    s_d.c4_s2  = s_q.c4_s1;
    s_d.c4_s3  = s_q.c4_s2;
    s_d.fp_s1  = frame_pulse_in_i;
    s_d.fp_s2  = s_q.fp_s1;
    s_d.fp_s3  = s_q.fp_s2;
    s_d.din_s1 = tdm_data_in_i;
    s_d.din_s2 = s_q.din_s1;
    s_d.por_s1 = power_up_reset_n_i;
    s_d.por_s2 = s_q.por_s1;
    s_d.por_s3 = s_q.por_s2;

    c_en     = s_q.regs[phone_tdm_pkg::IDX_SLOT_TIMING][phone_tdm_pkg::BIT_C_CHANNEL_EN];
    b1_en    = s_q.regs[phone_tdm_pkg::IDX_SLOT_TIMING][phone_tdm_pkg::BIT_B1_EN];
    b2_en    = s_q.regs[phone_tdm_pkg::IDX_SLOT_TIMING][phone_tdm_pkg::BIT_B2_EN];
    lb_in    = s_q.regs[phone_tdm_pkg::IDX_LOOPBACK][phone_tdm_pkg::BIT_INBOUND_LOOP];
    lb_out   = s_q.regs[phone_tdm_pkg::IDX_LOOPBACK][phone_tdm_pkg::BIT_OUTBOUND_LOOP];
    route_en = s_q.regs[phone_tdm_pkg::IDX_GENERAL][phone_tdm_pkg::BIT_ROUTE_EN];
    tone_mode = s_q.regs[phone_tdm_pkg::IDX_SIGNAL_PROC][phone_tdm_pkg::BIT_TONE_OPTION];

    c4_fall   = s_q.c4_s3 & ~s_q.c4_s2;
    fp_low    = ~s_q.fp_s2;
    fp_fall   = s_q.fp_s3 & ~s_q.fp_s2;
    // a fall with the pulse low restarts bit 0; a second-half fall opens the next bit
    drive_ev  = c4_fall & (fp_low | (s_q.framed & s_q.ph));
    sample_ev = c4_fall & ~fp_low & s_q.framed & ~s_q.ph;
    drive_bit = fp_low ? 8'h00 : s_q.bitcnt + 8'h01;

    // outbound loopback replaces the pin with our own driven bit
    rin = lb_out ? s_q.dout : s_q.din_s2;

    if (drive_ev) begin
      s_d.framed = 1'b1;
      s_d.ph     = 1'b0;
      s_d.bitcnt = drive_bit;
      if (drive_bit[2:0] == 3'h0) begin
        unique case (drive_bit[7:3])
          5'd0:    load_byte = s_q.regs[phone_tdm_pkg::IDX_CONTROL_SLOT];
          5'd1:    load_byte = b1_en ? pcm_tx_byte_i : 8'h00;
          5'd2:    load_byte = (b2_en && !b1_en) ? pcm_tx_byte_i : 8'h00;
          default: load_byte = 8'h00;
        endcase
        s_d.dout  = load_byte[7];
        s_d.tx_sh = {load_byte[6:0], 1'b0};
      end else begin
        s_d.dout  = s_q.tx_sh[7];
        s_d.tx_sh = {s_q.tx_sh[6:0], 1'b0};
      end
      unique case (drive_bit[7:3])
        5'd0: begin
          s_d.doe = c_en;
          if (lb_in && c_en) begin
            s_d.dout = s_q.last_in;
          end
        end
        5'd1: begin
          s_d.doe = 1'b1;
          if (lb_in && b1_en) begin
            s_d.dout = s_q.last_in;
          end else if (!b1_en) begin
            s_d.dout = 1'b0;
          end
        end
        5'd2: begin
          s_d.doe = 1'b1;
          if (lb_in && b2_en) begin
            s_d.dout = s_q.last_in;
          end else if (!(b2_en && !b1_en)) begin
            s_d.dout = 1'b0;
          end
        end
        default: s_d.doe = 1'b0;
      endcase
    end else if (c4_fall && !fp_low && s_q.framed) begin
      s_d.ph = 1'b1;
    end

    s_d.pcm_v = 1'b0;
    if (sample_ev) begin
      s_d.last_in = rin;
      rx_byte     = {s_q.rx_sh[6:0], rin};
      s_d.rx_sh   = rx_byte;
      if (s_q.bitcnt[2:0] == 3'h7) begin
        unique case (s_q.bitcnt[7:3])
          5'd0: s_d.cch_rx = rx_byte;
          5'd1: begin
            if (b1_en) begin
              s_d.pcm_rx = rx_byte;
              s_d.pcm_v  = 1'b1;
            end
          end
          5'd2: begin
            if (b2_en && !b1_en) begin
              s_d.pcm_rx = rx_byte;
              s_d.pcm_v  = 1'b1;
            end
          end
          default: s_d.pcm_v = 1'b0;
        endcase
      end
    end

    // register port
    wslot = reg_slot(reg_addr_i);
    rslot = reg_slot(reg_addr_i);
    if (reg_wr_i && wslot[4]) begin
      s_d.regs[wslot[3:0]] = reg_wdata_i;
    end
    s_d.rvalid = reg_rd_i;
    if (reg_rd_i) begin
      if (reg_addr_i == phone_tdm_pkg::ADDR_CONTROL_SLOT) begin
        s_d.rdata = s_q.cch_rx;
      end else if (rslot[4]) begin
        s_d.rdata = s_q.regs[rslot[3:0]];
      end else begin
        s_d.rdata = 8'h00;
      end
    end

    // watchdog; a correct key write beats an interval end in the same cycle
    key_wr = reg_wr_i && (reg_addr_i == phone_tdm_pkg::ADDR_WATCHDOG_KEY);
    key_ok = key_wr && (reg_wdata_i[phone_tdm_pkg::KEY_BITS-1:0] == phone_tdm_pkg::WATCHDOG_KEY);
    if (!s_q.por_s2) begin
      s_d.wout = 1'b1;
      s_d.wcnt = '0;
    end else if (!s_q.por_s3) begin
      s_d.wout = 1'b0;
      s_d.wcnt = '0;
    end else if (key_ok) begin
      s_d.wout = 1'b0;
      s_d.wcnt = '0;
    end else if (fp_fall) begin
      // wrong keys do not restart, so the interval simply runs out
      if (s_q.wcnt == WDOG_LAST) begin
        s_d.wcnt = '0;
        s_d.wout = ~s_q.wout;
      end else begin
        s_d.wcnt = s_q.wcnt + CW'(1);
      end
    end

    // tone control: half periods and warble step count in frame ticks
    coef = s_q.tsel ? s_q.regs[phone_tdm_pkg::IDX_TONE_COEF_2] : s_q.regs[phone_tdm_pkg::IDX_TONE_COEF_1];
    if (fp_fall) begin
      if (s_q.half_cnt >= coef) begin
        s_d.half_cnt = 8'h00;
        s_d.sq       = ~s_q.sq;
      end else begin
        s_d.half_cnt = s_q.half_cnt + 8'h01;
      end
      if (s_q.warb_cnt >= s_q.regs[phone_tdm_pkg::IDX_WARBLE_RATE]) begin
        s_d.warb_cnt = 8'h00;
        s_d.tsel     = ~s_q.tsel;
      end else begin
        s_d.warb_cnt = s_q.warb_cnt + 8'h01;
      end
    end
    s_d.mute  = tone_mode;
    s_d.gate  = route_en & tone_mode & s_q.sq;
    s_d.loud  = route_en;
    s_d.atten = s_q.regs[phone_tdm_pkg::IDX_CODEC_GAIN_2][phone_tdm_pkg::POS_ATTEN +: 2];

    // power-up reset reloads the map's reset values but keeps the synchronisers running
    if (!s_q.por_s2) begin
      s_d.regs   = rst_v.regs;
      s_d.framed = 1'b0;
      s_d.doe    = 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      s_q <= reset_state();
    end else begin
      s_q <= s_d;
    end
  end

  assign tdm_data_out_o            = s_q.dout;
  assign tdm_data_out_oe_o         = s_q.doe;
  assign reg_rdata_o               = s_q.rdata;
  assign reg_rvalid_o              = s_q.rvalid;
  assign pcm_rx_byte_o             = s_q.pcm_rx;
  assign pcm_rx_valid_o            = s_q.pcm_v;
  assign codec_tone_mute_o         = s_q.mute;
  assign tone_gate_o               = s_q.gate;
  assign loudness_enable_o         = s_q.loud;
  assign ringer_tone_attenuation_o = s_q.atten;
  assign watchdog_out_o            = s_q.wout;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);

  property p_wdog_high_in_por;
    !s_q.por_s2 |=> watchdog_out_o;
  endproperty
  a_wdog_high_in_por: assert property (p_wdog_high_in_por) else $error("watchdog low during power-up reset");

  property p_wdog_low_on_release;
    $rose(s_q.por_s2) |=> !watchdog_out_o && s_q.wcnt == '0;
  endproperty
  a_wdog_low_on_release: assert property (p_wdog_low_on_release) else $error("watchdog not low after release");

  property p_key_restart;
    s_q.por_s3 && s_q.por_s2 && key_ok |=> !watchdog_out_o && s_q.wcnt == '0;
  endproperty
  a_key_restart: assert property (p_key_restart) else $error("correct key did not restart timer");

  property p_wdog_toggle;
    s_q.por_s3 && s_q.por_s2 && !key_ok && fp_fall && s_q.wcnt == WDOG_LAST
      |=> watchdog_out_o != $past(watchdog_out_o) && s_q.wcnt == '0;
  endproperty
  a_wdog_toggle: assert property (p_wdog_toggle) else $error("watchdog did not toggle at interval end");

  property p_wdog_frame_only;
    s_q.por_s3 && s_q.por_s2 && !key_ok && !fp_fall |=> $stable(s_q.wcnt) && $stable(watchdog_out_o);
  endproperty
  a_wdog_frame_only: assert property (p_wdog_frame_only) else $error("watchdog moved without frame edge");

  property p_bad_key_ignored;
    s_q.por_s3 && s_q.por_s2 && key_wr && !key_ok && !fp_fall |=> $stable(s_q.wcnt);
  endproperty
  a_bad_key_ignored: assert property (p_bad_key_ignored) else $error("wrong key restarted timer");

  property p_cch_float;
    s_q.por_s2 && drive_ev && drive_bit[7:3] == 5'd0 && !c_en |=> !tdm_data_out_oe_o;
  endproperty
  a_cch_float: assert property (p_cch_float) else $error("control slot driven while disabled");

  property p_cch_msb;
    s_q.por_s2 && drive_ev && drive_bit == 8'h00 && c_en && !lb_in
      |=> tdm_data_out_oe_o && tdm_data_out_o == $past(s_q.regs[phone_tdm_pkg::IDX_CONTROL_SLOT][7]);
  endproperty
  a_cch_msb: assert property (p_cch_msb) else $error("control byte not sent msb first");

  property p_voice_zero;
    s_q.por_s2 && drive_ev && drive_bit[7:3] == 5'd1 && !b1_en |=> tdm_data_out_oe_o && !tdm_data_out_o;
  endproperty
  a_voice_zero: assert property (p_voice_zero) else $error("disabled voice slot not zero");

  property p_reserved_read;
    reg_rd_i && !rslot[4] && reg_addr_i != phone_tdm_pkg::ADDR_CONTROL_SLOT |=> reg_rvalid_o && reg_rdata_o == 8'h00;
  endproperty
  a_reserved_read: assert property (p_reserved_read) else $error("reserved read not zero");

  property p_cch_read;
    reg_rd_i && reg_addr_i == phone_tdm_pkg::ADDR_CONTROL_SLOT |=> reg_rdata_o == $past(s_q.cch_rx);
  endproperty
  a_cch_read: assert property (p_cch_read) else $error("control read not receive byte");

  property p_tone_gated;
    !route_en |=> !tone_gate_o && !loudness_enable_o;
  endproperty
  a_tone_gated: assert property (p_tone_gated) else $error("tone passed without route enable");

  c_wdog_timeout: cover property (s_q.por_s2 && fp_fall && s_q.wcnt == WDOG_LAST);
  c_pcm_rx:       cover property (pcm_rx_valid_o);
  c_cch_sent:     cover property (drive_ev && drive_bit == 8'h00 && c_en);
endmodule
`default_nettype wire

/* File: tb/tdm_line_partner.sv */
`timescale 1ns/1ps
`default_nettype none
// far-end transceiver: frames run back to back, slots 1..3 sent from send_i
module tdm_line_partner #(
  parameter int HALF_NS = 400
) (
  input  wire logic        line_out_i,
  input  wire logic        line_oe_i,
  input  wire logic [23:0] send_i,
  output logic             bit_clock_o,
  output logic             frame_pulse_o,
  output logic             line_in_o,
  output logic      [23:0] got_o,
  output logic      [2:0]  oe_o,
  output logic      [15:0] frames_o
);
  logic [8:0]  e;
  logic [23:0] got_w;
  logic [2:0]  oe_w;
  int          idx;
  initial begin
    {bit_clock_o, frame_pulse_o, line_in_o} = 3'b111;
    {got_o, got_w, oe_o, frames_o} = '0;
    oe_w = '1;
    e = 9'h1F0;
    forever begin
      #(HALF_NS) bit_clock_o = 1'b0;
      idx = 23 - 8 * e[8:4] - e[3:1];
      // unused slots carry a moving pattern, never a held level
      if (!e[0]) line_in_o = (e[8:4] < 3) ? send_i[idx] : e[4] ^ e[2];
      else if (e[8:4] < 3) begin
        got_w[idx] = line_out_i;
        oe_w[e[5:4]] = oe_w[e[5:4]] & line_oe_i;
      end
      #(HALF_NS) bit_clock_o = 1'b1;
      e = e + 9'h001;
      frame_pulse_o = (e != 9'h000);
      if (e == 9'h000) begin
        got_o = got_w;
        oe_o = oe_w;
        oe_w = '1;
        frames_o = frames_o + 16'h0001;
      end
    end
  end
endmodule
`default_nettype wire

/* File: tb/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int WDOG_TB_FRAMES = 2;
  localparam logic [7:0] RW [15] = '{8'h0A, 8'h0B, 8'h0E, 8'h0F, 8'h12, 8'h13, 8'h15, 8'h16,
                                     8'h1D, 8'h1E, 8'h20, 8'h21, 8'h23, 8'h24, 8'h26};
  localparam logic [7:0] RSV [4] = '{8'h00, 8'h10, 8'h25, 8'h3F};
  logic        clk_sys_i, reset_i, pwr_n, bclk, fp, din, dout, doe, reg_wr, reg_rd, reg_rv;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, pcm_tx, pcm_rx;
  logic        pcm_v, mute, gate, loud, wdog;
  logic [1:0]  att;
  logic [23:0] send, got;
  logic [2:0]  oe3;
  logic [15:0] frames;
  int          fail_count = 0;
  int          samples_checked = 0;
  int          cyc = 0;
  int          flips = 0;
  int          pcm_pulses = 0;

  phone_tdm_slot_watchdog_ctrl #(.WDOG_FRAMES(WDOG_TB_FRAMES)) dut (
    .clk_sys_i(clk_sys_i), .reset_i(reset_i), .power_up_reset_n_i(pwr_n),
    .bit_clock_in_i(bclk), .frame_pulse_in_i(fp), .tdm_data_in_i(din),
    .tdm_data_out_o(dout), .tdm_data_out_oe_o(doe), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata),
    .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata), .reg_rvalid_o(reg_rv),
    .pcm_tx_byte_i(pcm_tx), .pcm_rx_byte_o(pcm_rx), .pcm_rx_valid_o(pcm_v),
    .codec_tone_mute_o(mute), .tone_gate_o(gate), .loudness_enable_o(loud),
    .ringer_tone_attenuation_o(att), .watchdog_out_o(wdog));

  tdm_line_partner #(.HALF_NS(400)) line (
    .line_out_i(dout), .line_oe_i(doe), .send_i(send), .bit_clock_o(bclk), .frame_pulse_o(fp),
    .line_in_o(din), .got_o(got), .oe_o(oe3), .frames_o(frames));

  initial begin
    clk_sys_i = 1'b0;
    forever #50 clk_sys_i = ~clk_sys_i;
  end

  always @(gate) flips++;

  always @(negedge clk_sys_i) begin
    if (pcm_v === 1'b1) pcm_pulses++;
  end

  task automatic wrap_up();
    $display("checked %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // about 16 frames of 4096 cycles are needed
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 90000) begin
      fail_count++;
      $display("mismatch t=%0t run hung", $time);
      wrap_up();
    end
  end

  task automatic chk(input logic [7:0] g, input logic [7:0] x, input string what);
    samples_checked++;
    if (g !== x) begin
      fail_count++;
      $display("mismatch t=%0t %s got %h exp %h", $time, what, g, x);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys_i);
    {reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
    @(negedge clk_sys_i);
    reg_wr = 1'b0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] x, input string what);
    @(negedge clk_sys_i);
    {reg_addr, reg_rd} = {a, 1'b1};
    @(negedge clk_sys_i);
    reg_rd = 1'b0;
    for (int i = 0; i < 3 && reg_rv !== 1'b1; i++) @(negedge clk_sys_i);
    chk({7'h00, reg_rv}, 8'h01, "read answer");
    chk(reg_rdata, x, what);
  endtask

  // 600 cycles past a boundary: slots 1..3 are done, next frame edge far off
  task automatic wait_frames(input int n);
    repeat (n) @(frames);
    repeat (600) @(negedge clk_sys_i);
  endtask

  task automatic t_regs();
    for (int i = 0; i < 15; i++) rchk(RW[i], 8'h00, "reset value");
    for (int i = 0; i < 15; i++) wr_reg(RW[i], 8'hA5 ^ RW[i]);
    for (int i = 0; i < 15; i++) rchk(RW[i], 8'hA5 ^ RW[i], "readback");
    for (int i = 0; i < 4; i++) wr_reg(RSV[i], 8'hFF);
    for (int i = 0; i < 4; i++) rchk(RSV[i], 8'h00, "reserved");
    wr_reg(8'h11, 8'h0A);
    rchk(8'h11, 8'h00, "key unreadable");
    for (int i = 0; i < 15; i++) wr_reg(RW[i], 8'h00);
    $display("test regs done");
  endtask

  task automatic t_slots();
    logic [2:0] cfg [3];
    int         np;
    cfg = '{3'b011, 3'b100, 3'b110};
    np = 0;
    wr_reg(8'h14, 8'hC3);
    for (int i = 0; i < 3; i++) begin
      send[23:16] = (i == 0) ? 8'h96 : 8'h3C;
      wr_reg(8'h15, {5'h00, cfg[i]});
      wait_frames(2);
      chk({7'h00, oe3[0]}, {7'h00, cfg[i][0]}, "control oe");
      if (cfg[i][0]) chk(got[23:16], 8'hC3, "control out");
      rchk(8'h14, send[23:16], "control in");
      chk(got[15:8], cfg[i][1] ? 8'h71 : 8'h00, "slot 2 out");
      chk(got[7:0], (cfg[i][2] && !cfg[i][1]) ? 8'h71 : 8'h00, "slot 3 out");
      chk({6'h00, oe3[2:1]}, 8'h03, "voice oe");
      chk(pcm_rx, cfg[i][1] ? 8'h1E : 8'hE1, "pcm in");
      // one strobe per frame; two whole frames since the last mark
      if (i > 0) chk(8'(pcm_pulses - np), 8'h02, "pcm strobes");
      np = pcm_pulses;
    end
    $display("test slots done");
  endtask

  task automatic t_loop();
    wr_reg(8'h15, 8'h02);
    wr_reg(8'h16, 8'h01);
    wait_frames(2);
    chk(got[15:8], {send[16], send[15:9]}, "inbound slot 2");
    chk(got[7:0], 8'h00, "inbound disabled slot");
    wr_reg(8'h16, 8'h02);
    wr_reg(8'h15, 8'h03);
    wr_reg(8'h14, 8'hA5);
    wait_frames(2);
    chk(got[23:16], 8'hA5, "outbound pins");
    rchk(8'h14, 8'hA5, "outbound control");
    chk(pcm_rx, 8'h71, "outbound pcm");
    wr_reg(8'h16, 8'h00);
    $display("test loop done");
  endtask

  task automatic t_tone();
    int f0;
    wr_reg(8'h1E, 8'h01);
    wr_reg(8'h0F, 8'h01);
    for (int k = 0; k < 4; k++) begin
      wr_reg(8'h0B, 8'(k << 4));
      repeat (3) @(negedge clk_sys_i);
      chk({6'h00, att}, 8'(k), "attenuation");
    end
    chk({6'h00, mute, loud}, 8'h03, "tone mode");
    f0 = flips;
    wait_frames(1);
    chk({7'h00, flips != f0}, 8'h01, "tone gate runs");
    wr_reg(8'h0F, 8'h00);
    wr_reg(8'h1E, 8'h00);
    repeat (3) @(negedge clk_sys_i);
    chk({5'h00, mute, loud, gate}, 8'h00, "tone off");
    $display("test tone done");
  endtask

  task automatic t_wdog();
    @(negedge clk_sys_i);
    pwr_n = 1'b0;
    repeat (6) @(negedge clk_sys_i);
    chk({7'h00, wdog}, 8'h01, "held reset");
    pwr_n = 1'b1;
    repeat (6) @(negedge clk_sys_i);
    chk({7'h00, wdog}, 8'h00, "released");
    wait_frames(WDOG_TB_FRAMES - 1);
    chk({7'h00, wdog}, 8'h00, "before interval");
    wr_reg(8'h11, 8'hEA);
    wait_frames(WDOG_TB_FRAMES - 1);
    chk({7'h00, wdog}, 8'h00, "restarted");
    wr_reg(8'h11, 8'h0B);
    wait_frames(1);
    chk({7'h00, wdog}, 8'h01, "timeout");
    wait_frames(WDOG_TB_FRAMES);
    chk({7'h00, wdog}, 8'h00, "toggle");
    $display("test watchdog done");
  endtask

  initial begin
    {reset_i, reg_wr, reg_rd, pwr_n} = 4'b1001;
    {reg_addr, reg_wdata} = 16'h0000;
    pcm_tx = 8'h71;
    send = 24'h961EE1;
    repeat (5) @(negedge clk_sys_i);
    reset_i = 1'b0;
    t_regs();
    t_slots();
    t_loop();
    t_tone();
    t_wdog();
    wrap_up();
  end
endmodule
`default_nettype wire
